// [src/dsr_pkg.sv]
// shared constants and types of the drive status readout bank
// assumes one 100 MHz core clock and an APB master on the register port
// What this block does
// [R01] position as signed revolutions plus signed fraction
// [R02] revolution count preloadable, counts on from it
// [R03] external feedback selects the revolution source
// [R04] standard fast counter read as two words
// [R05] fast counters one and two split likewise
// [R06] signed speed per counter, ppr scaled, saturated
// [R07] analog value: gain, offset, filter, clamped
// [R08] speed function reports 8192 per 18750 rpm
// [R09] unity gain full scale equals rated speed
// [R10] other functions map +-10 V onto -8192..8191
// [R11] unassigned analog input is not sampled
// [R12] CAN controller state reported as a code
// [R13] received frame counter, 16 bit, wraps
// [R14] transmitted frame counter, 16 bit, wraps
// [R15] bus-off event counter, 16 bit, wraps
// [R16] lost frame counter, 16 bit, wraps
// [R17] 16384 fraction pulses per revolution
// [R18] low word read latches matching high word
// [R19] readout registers ignore host writes
package dsr_pkg;
  // clock and speed measurement window
  localparam int CLK_MHZ = 100;
  localparam int SPEED_WIN_US = 1000;
  localparam int SPEED_WIN_CYCLES = SPEED_WIN_US * CLK_MHZ;
  localparam logic signed [63:0] RPM_NUM = 64'(60_000_000 / SPEED_WIN_US);
  localparam logic signed [15:0] SPD_MAX = 16'sh7FFF;
  localparam logic signed [15:0] SPD_MIN = 16'sh8000;
  // position
  localparam logic signed [14:0] FRAC_MAX = 15'sh3FFF;
  // analog scaling
  localparam logic signed [63:0] GAIN_UNITY = 64'sd1000;
  localparam logic signed [63:0] SPD_INT_FS = 64'sd8192;
  localparam logic signed [63:0] SPD_RPM_FS = 64'sd18750;
  localparam logic signed [63:0] AIN_FS = 64'sd8191;
  localparam logic signed [13:0] AIN_MAX = 14'sh1FFF;
  localparam logic signed [13:0] AIN_MIN = 14'sh2000;
  localparam logic [3:0] FUNC_NONE = 4'h0;
  localparam logic [3:0] FUNC_SPEED_REF = 4'h2;
  // CAN controller state codes
  localparam logic [2:0] CAN_DISABLED = 3'h0;
  localparam logic [2:0] CAN_OK = 3'h2;
  localparam logic [2:0] CAN_WARN = 3'h3;
  localparam logic [2:0] CAN_PASSIVE = 3'h4;
  localparam logic [2:0] CAN_BUS_OFF = 3'h5;
  localparam logic [2:0] CAN_NO_SUPPLY = 3'h6;
  // register byte offsets
  localparam logic [7:0] OFS_STD_LO = 8'h00;
  localparam logic [7:0] OFS_STD_HI = 8'h04;
  localparam logic [7:0] OFS_C1_LO = 8'h08;
  localparam logic [7:0] OFS_C1_HI = 8'h0C;
  localparam logic [7:0] OFS_C2_LO = 8'h10;
  localparam logic [7:0] OFS_C2_HI = 8'h14;
  localparam logic [7:0] OFS_STD_SPD = 8'h18;
  localparam logic [7:0] OFS_C1_SPD = 8'h1C;
  localparam logic [7:0] OFS_C2_SPD = 8'h20;
  localparam logic [7:0] OFS_AIN1 = 8'h24;
  localparam logic [7:0] OFS_AIN2 = 8'h28;
  localparam logic [7:0] OFS_CAN_STATE = 8'h2C;
  localparam logic [7:0] OFS_CAN_RX = 8'h30;
  localparam logic [7:0] OFS_CAN_TX = 8'h34;
  localparam logic [7:0] OFS_CAN_BOFF = 8'h38;
  localparam logic [7:0] OFS_CAN_LOST = 8'h3C;
  localparam logic [7:0] OFS_REV = 8'h40;
  localparam logic [7:0] OFS_FRAC = 8'h44;
  localparam logic [7:0] OFS_CTRL = 8'h48;
  localparam logic [7:0] OFS_PRELOAD = 8'h4C;
  localparam logic [7:0] OFS_PPR0 = 8'h50;
  localparam logic [7:0] OFS_PPR1 = 8'h54;
  localparam logic [7:0] OFS_PPR2 = 8'h58;
  localparam logic [7:0] OFS_AIN1_CFG = 8'h5C;
  localparam logic [7:0] OFS_AIN2_CFG = 8'h60;
  localparam logic [7:0] OFS_AIN1_OFS = 8'h64;
  localparam logic [7:0] OFS_AIN2_OFS = 8'h68;
  localparam logic [7:0] OFS_RATED = 8'h6C;
  localparam logic [7:0] OFS_INT_STAT = 8'h70;
  localparam logic [7:0] OFS_INT_MASK = 8'h74;
  // control and interrupt fields
  localparam int CTRL_FB_SEL = 0;
  localparam int IRQ_W = 4;
  localparam int IRQ_BUSOFF = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_STATE = 2;
  localparam int IRQ_RX_WRAP = 3;
  // reset values
  localparam logic [15:0] RST_PPR = 16'h0400;
  localparam logic [15:0] RST_GAIN = 16'h03E8;
  localparam logic [15:0] RST_RATED = 16'h0BB8;
  // CAN event strobes, one cycle each
  typedef struct packed {
    logic rx;
    logic tx;
    logic busOff;
    logic lost;
  } dsr_canEvt_s;
  // analog configuration word
  typedef struct packed {
    logic [15:0] gain;
    logic [7:0] rsvd;
    logic [3:0] filt;
    logic [3:0] func;
  } dsr_ainCfg_s;
endpackage : dsr_pkg

// [src/dsr_pos_tracker.sv]
// user position tracker: revolutions plus signed fraction
// assumes one step strobe per sensor pulse, synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module dsr_pos_tracker
  import dsr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic stepEn,
  input wire logic stepFwd,
  input wire logic loadEn,
  input wire logic signed [15:0] loadRev,
  output logic signed [15:0] rev,
  output logic signed [14:0] frac
);
  // fraction follows the sign of the position, carries at 16384
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rev <= 16'sh0000;
      frac <= 15'sh0000;
    end
    else if (loadEn)
      rev <= loadRev; // R02
    else if (stepEn && stepFwd)
    begin
      if (frac == FRAC_MAX)
      begin
        rev <= rev + 16'sh0001; // R17
        frac <= 15'sh0000;
      end
      else if (frac == 15'sh0000 && rev < 16'sh0000)
      begin
        rev <= rev + 16'sh0001; // R01
        frac <= -FRAC_MAX;
      end
      else
        frac <= frac + 15'sh0001;
    end
    else if (stepEn)
    begin
      if (frac == -FRAC_MAX)
      begin
        rev <= rev - 16'sh0001; // R17
        frac <= 15'sh0000;
      end
      else if (frac == 15'sh0000 && rev > 16'sh0000)
      begin
        rev <= rev - 16'sh0001; // R01
        frac <= FRAC_MAX;
      end
      else
        frac <= frac - 15'sh0001;
    end
  end

  property p_fracCarry;
    @(posedge core_clk) disable iff (!rst_n)
    !loadEn && stepEn && stepFwd && frac == FRAC_MAX
      |=> frac == 15'sh0000 && rev == $past(rev) + 16'sh0001;
  endproperty
  a_fracCarry: assert property (p_fracCarry) // R17
    else $error("fraction did not carry into revolutions");

  property p_fracSign;
    @(posedge core_clk) disable iff (!rst_n)
    !loadEn && stepEn && !stepFwd && frac == 15'sh0000 && rev == 16'sh0000
      |=> frac == -15'sh0001 && rev == 16'sh0000;
  endproperty
  a_fracSign: assert property (p_fracSign) // R01
    else $error("backward fraction lost its sign");
endmodule : dsr_pos_tracker
`default_nettype wire

// [src/dsr_status_bank.sv]
// drive status readout bank with APB register slave
// assumes synchronous inputs on core_clk and an APB3 master
`timescale 1ns/1ps
`default_nettype none
module dsr_status_bank
  import dsr_pkg::*;
#(
  parameter int SPEED_WIN_CYC = SPEED_WIN_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic motorStep,
  input wire logic motorFwd,
  input wire logic extStep,
  input wire logic extFwd,
  input wire logic [2:0][31:0] cntValue,
  input wire logic [1:0][13:0] ainRaw,
  input wire logic [1:0] ainStrobe,
  input wire logic [2:0] canState,
  input wire dsr_canEvt_s canEvt,
  output logic irq
);
  // signed speed over one window, scaled by pulses per turn
  function automatic logic signed [15:0] spdCalc(
    input logic [31:0] delta,
    input logic [15:0] ppr
  );
    logic signed [63:0] v;
    v = 64'sh0000_0000_0000_0000;
    if (ppr != 16'h0000)
      v = (64'($signed(delta)) * RPM_NUM) / $signed({48'h0000_0000_0000, ppr});
    if (v > 64'(SPD_MAX))
      spdCalc = SPD_MAX;
    else if (v < 64'(SPD_MIN))
      spdCalc = SPD_MIN;
    else
      spdCalc = v[15:0];
  endfunction : spdCalc

  // gain, offset, unit scaling, then first order filter
  function automatic logic signed [13:0] ainCalc(
    input logic signed [13:0] raw,
    input dsr_ainCfg_s cfg,
    input logic signed [13:0] ofs,
    input logic [15:0] rated,
    input logic signed [13:0] prev
  );
    logic signed [63:0] v;
    logic signed [63:0] d;
    v = (64'(raw) * $signed({48'h0000_0000_0000, cfg.gain})) / GAIN_UNITY;
    v = v + 64'(ofs);
    if (cfg.func == FUNC_SPEED_REF)
      v = (v * $signed({48'h0000_0000_0000, rated}) * SPD_INT_FS)
        / (AIN_FS * SPD_RPM_FS);
    if (v > 64'(AIN_MAX))
      v = 64'(AIN_MAX);
    else if (v < 64'(AIN_MIN))
      v = 64'(AIN_MIN);
    d = (v - 64'(prev)) >>> cfg.filt;
    ainCalc = prev + d[13:0];
  endfunction : ainCalc

  logic fbSel;
  logic [2:0][15:0] ppr;
  dsr_ainCfg_s [1:0] ainCfg;
  logic [1:0][13:0] ainOfs;
  logic [15:0] rated;
  logic [2:0][15:0] hiShadow;
  logic [2:0][31:0] lastCnt;
  logic [2:0][15:0] speed;
  logic [1:0][13:0] ain;
  logic [31:0] winCnt;
  logic [15:0] rxCnt;
  logic [15:0] txCnt;
  logic [15:0] boffCnt;
  logic [15:0] lostCnt;
  logic [2:0] canStatePrev;
  logic [IRQ_W-1:0] intStat;
  logic [IRQ_W-1:0] intMask;
  logic [IRQ_W-1:0] intSet;
  logic signed [15:0] rev;
  logic signed [14:0] frac;
  logic wrEn;
  logic rdSetup;
  logic mapped;
  logic [31:0] rdData;

  // APB access phases; answers without wait states
  assign wrEn = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // position tracking, source picked by feedback select
  dsr_pos_tracker u_pos (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .stepEn(fbSel ? extStep : motorStep), // R03
    .stepFwd(fbSel ? extFwd : motorFwd), // R03
    .loadEn(wrEn && paddr == OFS_PRELOAD), // R02
    .loadRev(pwdata[15:0]),
    .rev(rev),
    .frac(frac)
  );

  // software configuration registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      fbSel <= 1'b0;
      ppr <= {3{RST_PPR}};
      ainCfg <= {2{RST_GAIN, 16'h0000}};
      ainOfs <= '0;
      rated <= RST_RATED;
      intMask <= '0;
    end
    else if (wrEn)
    begin
      case (paddr)
        OFS_CTRL: fbSel <= pwdata[CTRL_FB_SEL];
        OFS_PPR0: ppr[0] <= pwdata[15:0];
        OFS_PPR1: ppr[1] <= pwdata[15:0];
        OFS_PPR2: ppr[2] <= pwdata[15:0];
        OFS_AIN1_CFG: ainCfg[0] <= pwdata;
        OFS_AIN2_CFG: ainCfg[1] <= pwdata;
        OFS_AIN1_OFS: ainOfs[0] <= pwdata[13:0];
        OFS_AIN2_OFS: ainOfs[1] <= pwdata[13:0];
        OFS_RATED: rated <= pwdata[15:0];
        OFS_INT_MASK: intMask <= pwdata[IRQ_W-1:0];
        default: ; // R19
      endcase
    end
  end

  // high halves frozen when the matching low half is read
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      hiShadow <= '0;
    else if (rdSetup)
    begin
      if (paddr == OFS_STD_LO)
        hiShadow[0] <= cntValue[0][31:16]; // R18
      if (paddr == OFS_C1_LO)
        hiShadow[1] <= cntValue[1][31:16]; // R18
      if (paddr == OFS_C2_LO)
        hiShadow[2] <= cntValue[2][31:16]; // R18
    end
  end

  // speed window divider and per-counter speed
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      winCnt <= 32'h0000_0000;
      lastCnt <= '0;
      speed <= '0;
    end
    else if (winCnt == 32'(SPEED_WIN_CYC - 1))
    begin
      winCnt <= 32'h0000_0000;
      for (int i = 0; i < 3; i++)
      begin
        speed[i] <= spdCalc(cntValue[i] - lastCnt[i], ppr[i]); // R06
        lastCnt[i] <= cntValue[i];
      end
    end
    else
      winCnt <= winCnt + 32'h0000_0001;
  end

  // analog readings, only for inputs with a function
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ain <= '0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (ainStrobe[i] && ainCfg[i].func != FUNC_NONE) // R11
          ain[i] <= ainCalc($signed(ainRaw[i]), ainCfg[i], // R07 R08 R09 R10
            $signed(ainOfs[i]), rated, $signed(ain[i]));
      end
    end
  end

  // CAN traffic counters, each wraps past its maximum
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rxCnt <= 16'h0000;
      txCnt <= 16'h0000;
      boffCnt <= 16'h0000;
      lostCnt <= 16'h0000;
    end
    else
    begin
      if (canEvt.rx)
        rxCnt <= rxCnt + 16'h0001; // R13
      if (canEvt.tx)
        txCnt <= txCnt + 16'h0001; // R14
      if (canEvt.busOff)
        boffCnt <= boffCnt + 16'h0001; // R15
      if (canEvt.lost)
        lostCnt <= lostCnt + 16'h0001; // R16
    end
  end

  // interrupt events
  always_comb
  begin
    intSet = '0;
    intSet[IRQ_BUSOFF] = canEvt.busOff;
    intSet[IRQ_LOST] = canEvt.lost;
    intSet[IRQ_STATE] = canState != canStatePrev;
    intSet[IRQ_RX_WRAP] = canEvt.rx && rxCnt == 16'hFFFF;
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      intStat <= '0;
      canStatePrev <= CAN_DISABLED;
      irq <= 1'b0;
    end
    else
    begin
      canStatePrev <= canState;
      if (wrEn && paddr == OFS_INT_STAT)
        intStat <= (intStat & ~pwdata[IRQ_W-1:0]) | intSet;
      else
        intStat <= intStat | intSet;
      irq <= |(intStat & intMask);
    end
  end

  // read multiplexer and address decode
  always_comb
  begin
    mapped = 1'b1;
    rdData = 32'h0000_0000;
    case (paddr)
      OFS_STD_LO: rdData = {16'h0000, cntValue[0][15:0]}; // R04
      OFS_STD_HI: rdData = {16'h0000, hiShadow[0]}; // R04
      OFS_C1_LO: rdData = {16'h0000, cntValue[1][15:0]}; // R05
      OFS_C1_HI: rdData = {16'h0000, hiShadow[1]}; // R05
      OFS_C2_LO: rdData = {16'h0000, cntValue[2][15:0]}; // R05
      OFS_C2_HI: rdData = {16'h0000, hiShadow[2]}; // R05
      OFS_STD_SPD: rdData = {16'h0000, speed[0]};
      OFS_C1_SPD: rdData = {16'h0000, speed[1]};
      OFS_C2_SPD: rdData = {16'h0000, speed[2]};
      OFS_AIN1: rdData = {18'h0_0000, ain[0]};
      OFS_AIN2: rdData = {18'h0_0000, ain[1]};
      OFS_CAN_STATE: rdData = {29'h0000_0000, canState}; // R12
      OFS_CAN_RX: rdData = {16'h0000, rxCnt};
      OFS_CAN_TX: rdData = {16'h0000, txCnt};
      OFS_CAN_BOFF: rdData = {16'h0000, boffCnt};
      OFS_CAN_LOST: rdData = {16'h0000, lostCnt};
      OFS_REV: rdData = {16'h0000, rev}; // R01
      OFS_FRAC: rdData = {17'h0_0000, frac}; // R01
      OFS_CTRL: rdData = {31'h0000_0000, fbSel};
      OFS_PPR0: rdData = {16'h0000, ppr[0]};
      OFS_PPR1: rdData = {16'h0000, ppr[1]};
      OFS_PPR2: rdData = {16'h0000, ppr[2]};
      OFS_AIN1_CFG: rdData = ainCfg[0];
      OFS_AIN2_CFG: rdData = ainCfg[1];
      OFS_AIN1_OFS: rdData = {18'h0_0000, ainOfs[0]};
      OFS_AIN2_OFS: rdData = {18'h0_0000, ainOfs[1]};
      OFS_RATED: rdData = {16'h0000, rated};
      OFS_INT_STAT: rdData = {28'h000_0000, intStat};
      OFS_INT_MASK: rdData = {28'h000_0000, intMask};
      default: mapped = 1'b0;
    endcase
  end

  // read data registered in the setup cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= pwrite ? 32'h0000_0000 : rdData;
  end

  sequence s_rdSetup(logic [7:0] addr);
    psel && !penable && !pwrite && paddr == addr;
  endsequence

  property p_hiLatch;
    @(posedge core_clk) disable iff (!rst_n)
    s_rdSetup(OFS_STD_LO) |=> hiShadow[0] == $past(cntValue[0][31:16]);
  endproperty
  a_hiLatch: assert property (p_hiLatch) // R18
    else $error("high word not latched on low read");

  property p_canState;
    @(posedge core_clk) disable iff (!rst_n)
    s_rdSetup(OFS_CAN_STATE) |=> prdata == {29'h0000_0000, $past(canState)};
  endproperty
  a_canState: assert property (p_canState) // R12
    else $error("controller state read back wrong");

  property p_ainHold;
    @(posedge core_clk) disable iff (!rst_n)
    ainCfg[0].func == FUNC_NONE |=> $stable(ain[0]);
  endproperty
  a_ainHold: assert property (p_ainHold) // R11
    else $error("unassigned analog input changed");

  property p_rxWrap;
    @(posedge core_clk) disable iff (!rst_n)
    canEvt.rx && rxCnt == 16'hFFFF |=> rxCnt == 16'h0000 ##1 intStat[IRQ_RX_WRAP];
  endproperty
  a_rxWrap: assert property (p_rxWrap) // R13
    else $error("receive counter did not wrap");

  property p_txInc;
    @(posedge core_clk) disable iff (!rst_n)
    canEvt.tx |=> txCnt == $past(txCnt) + 16'h0001;
  endproperty
  a_txInc: assert property (p_txInc) // R14
    else $error("transmit counter missed a frame");

  property p_boffInc;
    @(posedge core_clk) disable iff (!rst_n)
    canEvt.busOff |=> boffCnt == $past(boffCnt) + 16'h0001 && intStat[IRQ_BUSOFF];
  endproperty
  a_boffInc: assert property (p_boffInc) // R15
    else $error("bus-off event not counted");

  property p_lostHold;
    @(posedge core_clk) disable iff (!rst_n)
    !canEvt.lost [*2] |-> $stable(lostCnt);
  endproperty
  a_lostHold: assert property (p_lostHold) // R16
    else $error("lost counter moved without an event");

  property p_roWrite;
    @(posedge core_clk) disable iff (!rst_n)
    wrEn && paddr == OFS_CAN_RX && !canEvt.rx |=> rxCnt == $past(rxCnt);
  endproperty
  a_roWrite: assert property (p_roWrite) // R19
    else $error("write changed a readout register");
endmodule : dsr_status_bank
`default_nettype wire

// [verification/dsr_apb_host.sv]
// APB host model: master side of the status bank register port
// assumes one rising-edge core clock shared with the bank
`timescale 1ns/1ps
`default_nettype none
module dsr_apb_host
(
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // bus idle at time zero
  initial
  begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rdat, output logic err);
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    while (pready !== 1'h1)
      @(posedge core_clk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    pwdata <= ~wd; // released data does not keep its last value
  endtask : xfer
endmodule : dsr_apb_host
`default_nettype wire

// [verification/drive_status_readout_bank_bench.sv]
// self-checking bench of the drive status readout bank
// assumes dsr_apb_host as bus master and the design sources
`timescale 1ns/1ps
`default_nettype none
module drive_status_readout_bank_bench
  import dsr_pkg::*;
;
  localparam int WIN = 20;
  localparam logic [7:0] CANOFS [4] = '{OFS_CAN_RX, OFS_CAN_TX, OFS_CAN_BOFF, OFS_CAN_LOST};
  logic coreClk = 1'h0;
  logic rstN = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic motorStep = 1'h0, motorFwd = 1'h0, extStep = 1'h0, extFwd = 1'h0;
  logic [2:0][31:0] cntValue = '0;
  logic [1:0][13:0] ainRaw = '0;
  logic [1:0] ainStrobe = '0;
  logic [2:0] canState = '0;
  dsr_canEvt_s canEvt = '0;
  logic ramp = 1'h0;
  int mismatches = 0;
  int nCompared = 0;

  // 100 MHz core clock
  always #5 coreClk = ~coreClk;

  // counters one and two ramp at fixed rates for the speed test
  always @(posedge coreClk)
    if (ramp)
    begin
      cntValue[1] <= cntValue[1] + 32'h0000_0001;
      cntValue[2] <= cntValue[2] - 32'h0000_0064;
    end

  dsr_status_bank #(.SPEED_WIN_CYC(WIN)) dsr_status_bank_i (
    .core_clk(coreClk), .rst_n(rstN), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motorStep(motorStep), .motorFwd(motorFwd), .extStep(extStep), .extFwd(extFwd),
    .cntValue(cntValue), .ainRaw(ainRaw), .ainStrobe(ainStrobe), .canState(canState),
    .canEvt(canEvt), .irq(irq));

  dsr_apb_host dsr_apb_host_i (
    .core_clk(coreClk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // read a register and compare its low w bits
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input int w);
    logic [31:0] m;
    m = (w == 32) ? 32'hFFFF_FFFF : (32'h0000_0001 << w) - 32'h0000_0001;
    dsr_apb_host_i.xfer(1'h0, a, 32'h0000_0000, rd, err);
    chk($sformatf("reg %h", a), exp & m, rd & m);
  endtask : rdChk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    dsr_apb_host_i.xfer(1'h1, a, d, rd, err);
  endtask : wr

  // n position steps: external source one way, motor sensor the other
  task automatic steps(input int n, input logic fwd);
    @(posedge coreClk);
    extFwd <= fwd;
    motorFwd <= !fwd;
    extStep <= 1'h1;
    motorStep <= 1'h1;
    repeat (n) @(posedge coreClk);
    extStep <= 1'h0;
    motorStep <= 1'h0;
    repeat (2) @(posedge coreClk);
  endtask : steps

  // one analog sample strobe
  task automatic ain(input int ch, input logic [13:0] raw);
    @(posedge coreClk);
    ainRaw[ch] <= raw;
    ainStrobe[ch] <= 1'h1;
    @(posedge coreClk);
    ainStrobe[ch] <= 1'h0;
    repeat (2) @(posedge coreClk);
  endtask : ain

  task automatic chkIrq(input logic exp);
    repeat (3) @(posedge coreClk);
    @(negedge coreClk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask : chkIrq

  // expected speed for a per-cycle count rate d
  function automatic logic [31:0] expSpd(input longint d, input longint ppr);
    longint r;
    r = d * WIN * 60000 / ppr;
    if (r > 32767) r = 32767;
    if (r < -32768) r = -32768;
    return {16'h0, r[15:0]};
  endfunction : expSpd

  // expected analog reading at unity gain, rated speed 3000
  function automatic logic [13:0] expAin(input longint raw, input longint ofs, input logic spd);
    longint v;
    v = raw + ofs;
    if (spd) v = v * 3000 * 8192 / (8191 * 18750);
    if (v > 8191) v = 8191;
    if (v < -8192) v = -8192;
    return v[13:0];
  endfunction : expAin

  task automatic results();
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // watchdog: tests take about 82k cycles, limit at 95k
  initial
  begin
    #950_000;
    mismatches++;
    results();
  end

  // test sequence
  initial
  begin
    logic [31:0] v;
    void'($urandom(18));
    repeat (8) @(posedge coreClk);
    rstN <= 1'h1;
    foreach (CANOFS[i]) rdChk(CANOFS[i], 32'h0000_0000, 16);
    for (int c = 0; c < 7; c++)
    begin
      canState <= 3'(c);
      rdChk(OFS_CAN_STATE, 32'(c), 3);
    end
    $display("test reset and state codes done");
    for (int k = 0; k < 3; k++)
    begin
      v = $urandom();
      cntValue[k] <= v;
      rdChk(8'(8 * k), {16'h0, v[15:0]}, 16);
      cntValue[k] <= ~v;
      rdChk(8'(8 * k + 4), {16'h0, v[31:16]}, 16);
    end
    wr(OFS_PPR1, 32'h0000_03E8);
    ramp <= 1'h1;
    repeat (60) @(posedge coreClk);
    rdChk(OFS_STD_SPD, 32'h0000_0000, 16);
    rdChk(OFS_C1_SPD, expSpd(1, 1000), 16);
    rdChk(OFS_C2_SPD, expSpd(-100, 1024), 16);
    ramp <= 1'h0;
    $display("test fast counters done");
    wr(OFS_CTRL, 32'h0000_0001);
    steps(8192, 1'h0);
    rdChk(OFS_REV, 32'h0000_0000, 16);
    rdChk(OFS_FRAC, 32'h0000_6000, 15);
    steps(8192, 1'h0);
    rdChk(OFS_REV, 32'h0000_FFFF, 16);
    rdChk(OFS_FRAC, 32'h0000_0000, 15);
    wr(OFS_PRELOAD, 32'h0000_0005);
    wr(OFS_REV, $urandom());
    rdChk(OFS_REV, 32'h0000_0005, 16);
    steps(1, 1'h1);
    rdChk(OFS_FRAC, 32'h0000_0001, 15);
    rdChk(OFS_REV, 32'h0000_0005, 16);
    steps(2, 1'h0);
    rdChk(OFS_REV, 32'h0000_0004, 16);
    rdChk(OFS_FRAC, 32'h0000_3FFF, 15);
    steps(1, 1'h1);
    rdChk(OFS_REV, 32'h0000_0005, 16);
    rdChk(OFS_FRAC, 32'h0000_0000, 15);
    wr(OFS_CTRL, 32'h0000_0000);
    steps(1, 1'h0);
    rdChk(OFS_FRAC, 32'h0000_0001, 15);
    $display("test position done");
    v = $urandom();
    ain(0, v[13:0]);
    rdChk(OFS_AIN1, 32'h0000_0000, 32);
    wr(OFS_AIN1_CFG, 32'h03E8_0001);
    ain(0, v[13:0]);
    rdChk(OFS_AIN1, expAin(longint'($signed(v[13:0])), 0, 1'h0), 32);
    wr(OFS_AIN1_OFS, 32'h0000_0064);
    ain(0, 14'h1FD6);
    rdChk(OFS_AIN1, expAin(8150, 100, 1'h0), 32);
    wr(OFS_RATED, 32'h0000_0BB8);
    wr(OFS_AIN2_CFG, 32'h03E8_0002);
    ain(1, 14'h1FFF);
    rdChk(OFS_AIN2, expAin(8191, 0, 1'h1), 32);
    ain(1, 14'h2000);
    rdChk(OFS_AIN2, expAin(-8192, 0, 1'h1), 32);
    $display("test analog done");
    wr(OFS_CAN_RX, $urandom());
    rdChk(OFS_CAN_RX, 32'h0000_0000, 16);
    dsr_apb_host_i.xfer(1'h0, 8'hFC, 32'h0000_0000, rd, err);
    chk("unmapped slverr", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    wr(OFS_INT_STAT, 32'h0000_000F);
    canEvt <= 4'hF;
    repeat (65537) @(posedge coreClk);
    canEvt <= 4'h0;
    foreach (CANOFS[i]) rdChk(CANOFS[i], 32'h0000_0001, 16);
    chkIrq(1'h0);
    rdChk(OFS_INT_STAT, 32'h0000_000B, 4);
    wr(OFS_INT_MASK, 32'h0000_0001);
    chkIrq(1'h1);
    wr(OFS_INT_STAT, 32'h0000_000F);
    chkIrq(1'h0);
    rdChk(OFS_INT_STAT, 32'h0000_0000, 4);
    $display("test CAN counters and interrupt done");
    results();
  end
endmodule : drive_status_readout_bank_bench
`default_nettype wire
